// *** bench/tb_time_word_decoder.sv ***
// Self-checking bench for the time information word decoder
`timescale 1ns/100ps
module tb_time_word_decoder import time_word_pkg::*;;
   logic core_clk, rst_n, psel, penable, pwrite, pready_q, pslverr_q, err;
   logic [ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata_q, rd;
   logic word_valid, ref_frame, standard_time_q, zone_reserved_q;
   logic [FMT_W-1:0] info_word_format_code;
   logic [PAY_W-1:0] info_word_payload;
   logic [MONTH_W-1:0] month_q;
   logic [4:0] day_q, year_q, hour_q, zone_code_q;
   logic [SEC_W-1:0] coarse_sec_q, accurate_sec_q;
   logic [5:0] minute_q, fine_sec_q;
   logic signed [OFS_W-1:0] zone_offset_q;
   logic date_valid_q, time_valid_q, zone_valid_q;
   int errors = 0;
   int n_compared = 0;
   int odd_ofs[8] = '{210, 270, 330, 0, 345, 390, 570, -210};
   time_word_decoder dut_u (.core_clk, .rst_n, .paddr, .psel, .penable,
      .pwrite, .pwdata, .prdata_q, .pready_q, .pslverr_q, .word_valid,
      .info_word_format_code, .info_word_payload, .ref_frame, .month_q,
      .day_q, .year_q, .coarse_sec_q, .minute_q, .hour_q, .accurate_sec_q,
      .fine_sec_q, .standard_time_q, .zone_code_q, .zone_offset_q,
      .zone_reserved_q, .date_valid_q, .time_valid_q, .zone_valid_q);
   time_word_source src_u (.core_clk, .word_valid, .info_word_format_code,
      .info_word_payload, .ref_frame);
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic stop_test;
      $display("compared %0d, errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Waits for pready without assuming the slave's latency
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge core_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= wr;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
      end while (pready_q !== 1'b1 && n < 50);
      if (n >= 50)
         errors++;
      rd = prdata_q;
      err = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   function automatic int zone_min(input int c);
      if (c <= 12)
         return c * 60;
      if (c <= 20)
         return odd_ofs[c-13];
      return (c - 32) * 60;
   endfunction
   initial begin
      rst_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      apb(1'b0, REG_CTRL, 32'h0);
      check(rd, 32'h1);
      check({date_valid_q, time_valid_q, zone_valid_q, month_q, fine_sec_q,
             zone_offset_q}, 32'h0);
      src_u.send(FMT_DATE, {4'hC, 5'h1F, 5'h1A});
      #1;
      check({month_q, day_q, year_q}, {4'hC, 5'h1F, 5'h1A});
      check({date_valid_q, time_valid_q, zone_valid_q}, 3'h4);
      src_u.ref_send({3'h5, 6'h3B, 5'h17});
      #1;
      check({coarse_sec_q, minute_q, hour_q, time_valid_q},
            {3'h5, 6'h3B, 5'h17, 1'b1});
      for (int c = 0; c < 32; c++) begin
         src_u.send(FMT_SYS, {c[2:0], 1'b0, c[0], c[4:0], 3'h2, c[0]});
         #1;
         check({accurate_sec_q, standard_time_q, zone_code_q, zone_valid_q},
               {c[2:0], c[0], c[4:0], 1'b1});
         check(fine_sec_q, ((40 + c % 8) * 60) / 64);
         check({{21{zone_offset_q[10]}}, zone_offset_q}, zone_min(c));
         check({zone_reserved_q, standard_time_q}, {c == 16, c[0]});
      end
      // Subtype outside the time set must leave every time output alone
      src_u.send(FMT_SYS, {3'h0, 1'b0, 1'b0, 5'h03, 4'h6});
      #1;
      check({zone_valid_q, zone_code_q, accurate_sec_q, standard_time_q,
             fine_sec_q, zone_offset_q},
            {1'b0, 5'h1F, 3'h7, 1'b1, 6'h2C, -11'sd60});
      apb(1'b0, REG_TIME, 32'h0);
      check(rd, 32'h7517_3B2C);
      apb(1'b0, REG_ZONE, 32'h0);
      check(rd, 32'h07C4_011F);
      apb(1'b0, REG_STAT, 32'h0);
      check({rd[15:8], rd[3:0]}, {8'h01, 4'hF});
      apb(1'b1, REG_STAT, 32'h0000_010F);
      apb(1'b0, REG_STAT, 32'h0);
      check({rd[15:8], rd[3:0]}, 12'h000);
      for (int f = 0; f < 8; f++) begin
         if (f != 1 && f != 2 && f != 5) begin
            src_u.send(f[2:0], 14'h0421);
            #1;
            check({date_valid_q, time_valid_q, zone_valid_q, month_q},
                  {3'h0, 4'hC});
         end
      end
      apb(1'b1, REG_CTRL, 32'h0);
      src_u.send(FMT_DATE, 14'h0421);
      #1;
      check({date_valid_q, month_q}, {1'b0, 4'hC});
      apb(1'b1, REG_CTRL, 32'h1);
      apb(1'b0, REG_DATE, 32'h0);
      check(rd, {18'h0, 4'hC, 5'h1F, 5'h1A});
      apb(1'b0, 12'h020, 32'h0);
      check({err, rd[30:0]}, 32'h8000_0000);
      stop_test;
   end
   // Whole run needs well under a thousand cycles
   initial begin
      #100000;
      errors++;
      stop_test;
   end
endmodule

// *** bench/time_word_source.sv ***
// Behavioural transmitter model feeding block information words
`timescale 1ns/100ps
module time_word_source import time_word_pkg::*; (
   input wire logic core_clk,
   output logic word_valid,
   output logic [FMT_W-1:0] info_word_format_code,
   output logic [PAY_W-1:0] info_word_payload,
   output logic ref_frame
);
   initial begin
      word_valid = 1'b0;
      info_word_format_code = 3'h0;
      info_word_payload = 14'h0000;
      ref_frame = 1'b0;
   end
   // Lines are inverted after each word so stale data never looks valid
   task automatic send(input logic [2:0] fmt, input logic [13:0] pay);
      @(posedge core_clk);
      word_valid <= 1'b1;
      info_word_format_code <= fmt;
      info_word_payload <= pay;
      @(posedge core_clk);
      word_valid <= 1'b0;
      info_word_format_code <= ~fmt;
      info_word_payload <= ~pay;
   endtask
   // Time word sent while frame zero of cycle zero is on air
   task automatic ref_send(input logic [13:0] pay);
      @(posedge core_clk);
      ref_frame <= 1'b1;
      send(FMT_TIME, pay);
      ref_frame <= 1'b0;
   endtask
endmodule

// *** hdl/seconds_refiner.sv ***
// Combines coarse and accurate seconds into whole seconds
`timescale 1ns/100ps
module seconds_refiner import time_word_pkg::*; (
   input wire logic [SEC_W-1:0] coarse_sec,
   input wire logic [SEC_W-1:0] accurate_sec,
   output logic [FINE_W-1:0] fine_sec
);
   localparam logic [9:0] SEC_PER_16 = 10'h00F;
   logic [5:0] sixty_fourths;
   logic [9:0] scaled;
   // Coarse eighths are eight 1/64 steps, so the sum is a plain concatenation
   assign sixty_fourths = {coarse_sec, accurate_sec};
   // 60/64 equals 15/16; truncation keeps the result within one second
   assign scaled = {4'h0, sixty_fourths} * SEC_PER_16;
   assign fine_sec = scaled[9:4];
endmodule

// *** hdl/time_word_decoder.sv ***
// Time information word decoder with APB status and control registers
//
// Decided for this implementation: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
module time_word_decoder import time_word_pkg::*; (
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_q,
   output logic pready_q,
   output logic pslverr_q,
   input wire logic word_valid,
   input wire logic [FMT_W-1:0] info_word_format_code,
   input wire logic [PAY_W-1:0] info_word_payload,
   input wire logic ref_frame,
   output logic [MONTH_W-1:0] month_q,
   output logic [DAY_W-1:0] day_q,
   output logic [YEAR_W-1:0] year_q,
   output logic [SEC_W-1:0] coarse_sec_q,
   output logic [MIN_W-1:0] minute_q,
   output logic [HOUR_W-1:0] hour_q,
   output logic [SEC_W-1:0] accurate_sec_q,
   output logic [FINE_W-1:0] fine_sec_q,
   output logic standard_time_q,
   output logic [ZONE_W-1:0] zone_code_q,
   output logic signed [OFS_W-1:0] zone_offset_q,
   output logic zone_reserved_q,
   output logic date_valid_q,
   output logic time_valid_q,
   output logic zone_valid_q
);
   logic en_q;
   logic date_seen_q;
   logic time_seen_q;
   logic zone_seen_q;
   logic ref_ok_q;
   logic [CNT_W-1:0] ign_cnt_q;
   logic [CNT_W-1:0] ign_cnt_d;
   logic [SEC_W-1:0] csec_d;
   logic [SEC_W-1:0] asec_d;
   logic [FINE_W-1:0] fine_d;
   logic signed [OFS_W-1:0] ofs_d;
   logic rsvd_d;

   // Word classification; the payload means nothing without its format
   wire take = word_valid & en_q;
   wire is_date = take & (info_word_format_code == FMT_DATE);
   wire is_time = take & (info_word_format_code == FMT_TIME);
   wire is_sys = take & (info_word_format_code == FMT_SYS);
   wire [SUB_W-1:0] subtype = info_word_payload[SUB_LSB +: SUB_W];
   wire sub_ok = (subtype == SUB_TIME_A) | (subtype == SUB_TIME_B);
   wire is_zone = is_sys & sub_ok;
   wire is_ign = is_sys & ~sub_ok;
   wire any_time = is_date | is_time | is_zone;

   wire [SEC_W-1:0] pay_csec = info_word_payload[CSEC_LSB +: SEC_W];
   wire [SEC_W-1:0] pay_asec = info_word_payload[ASEC_LSB +: SEC_W];
   wire [ZONE_W-1:0] pay_zone = info_word_payload[ZONE_LSB +: ZONE_W];

   assign csec_d = is_time ? pay_csec : coarse_sec_q;
   assign asec_d = is_zone ? pay_asec : accurate_sec_q;

   seconds_refiner u_refiner (
      .coarse_sec(csec_d),
      .accurate_sec(asec_d),
      .fine_sec(fine_d)
   );

   zone_offset_map u_zone_map (
      .zone_code(pay_zone),
      .offset_min(ofs_d),
      .reserved(rsvd_d)
   );

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         month_q <= '0;
         day_q <= '0;
         year_q <= '0;
      end else if (is_date) begin
         month_q <= info_word_payload[MONTH_LSB +: MONTH_W];
         day_q <= info_word_payload[DAY_LSB +: DAY_W];
         year_q <= info_word_payload[YEAR_LSB +: YEAR_W];
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         minute_q <= '0;
         hour_q <= '0;
      end else if (is_time) begin
         minute_q <= info_word_payload[MIN_LSB +: MIN_W];
         hour_q <= info_word_payload[HOUR_LSB +: HOUR_W];
      end
   end

   // Fine seconds follow either half, so both sources stay consistent
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         coarse_sec_q <= '0;
         accurate_sec_q <= '0;
         fine_sec_q <= '0;
      end else begin
         coarse_sec_q <= csec_d;
         accurate_sec_q <= asec_d;
         fine_sec_q <= fine_d;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         standard_time_q <= 1'b0;
         zone_code_q <= '0;
         zone_offset_q <= '0;
         zone_reserved_q <= 1'b0;
      end else if (is_zone) begin
         standard_time_q <= info_word_payload[DST_BIT];
         zone_code_q <= pay_zone;
         zone_offset_q <= ofs_d;
         zone_reserved_q <= rsvd_d;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         date_valid_q <= 1'b0;
         time_valid_q <= 1'b0;
         zone_valid_q <= 1'b0;
      end else begin
         date_valid_q <= is_date;
         time_valid_q <= is_time;
         zone_valid_q <= is_zone;
      end
   end

   // APB slave: one wait state, so every output leaves a flip-flop
   wire apb_acc = psel & penable;
   wire apb_first = apb_acc & ~pready_q;
   wire apb_wr = apb_acc & pready_q & pwrite;
   wire hit_date = paddr == REG_DATE;
   wire hit_time = paddr == REG_TIME;
   wire hit_zone = paddr == REG_ZONE;
   wire hit_ctrl = paddr == REG_CTRL;
   wire hit_stat = paddr == REG_STAT;
   wire mapped = hit_date | hit_time | hit_zone | hit_ctrl | hit_stat;

   wire [31:0] rd_date = 32'({month_q, day_q, year_q});
   wire [31:0] rd_time = (32'(accurate_sec_q) << T_ASEC_LSB)
                       | (32'(coarse_sec_q) << T_CSEC_LSB)
                       | (32'(hour_q) << T_HOUR_LSB)
                       | (32'(minute_q) << T_MIN_LSB)
                       | 32'(fine_sec_q);
   wire [31:0] rd_zone = (32'({5'h00, zone_offset_q}) << Z_OFS_LSB)
                       | (32'(zone_reserved_q) << Z_RSVD_BIT)
                       | (32'(standard_time_q) << Z_STD_BIT)
                       | 32'(zone_code_q);
   wire [31:0] rd_ctrl = 32'(en_q) << CTRL_EN_BIT;
   wire [31:0] rd_stat = (32'(ign_cnt_q) << STAT_CNT_LSB)
                       | (32'(ref_ok_q) << STAT_REF_BIT)
                       | (32'(zone_seen_q) << STAT_ZONE_BIT)
                       | (32'(time_seen_q) << STAT_TIME_BIT)
                       | (32'(date_seen_q) << STAT_DATE_BIT);
   wire [31:0] rd_mux = hit_date ? rd_date :
                        hit_time ? rd_time :
                        hit_zone ? rd_zone :
                        hit_ctrl ? rd_ctrl :
                        hit_stat ? rd_stat : 32'h0000_0000;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= '0;
      end else begin
         pready_q <= apb_first;
         pslverr_q <= apb_first & ~mapped;
         if (apb_first) begin
            prdata_q <= rd_mux;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         en_q <= CTRL_EN_RST;
      end else if (apb_wr & hit_ctrl) begin
         en_q <= pwdata[CTRL_EN_BIT];
      end
   end

   // Sticky status, write one to clear; an event in the clear cycle wins
   wire stat_wr = apb_wr & hit_stat;
   wire clr_date = stat_wr & pwdata[STAT_DATE_BIT];
   wire clr_time = stat_wr & pwdata[STAT_TIME_BIT];
   wire clr_zone = stat_wr & pwdata[STAT_ZONE_BIT];
   wire clr_ref = stat_wr & pwdata[STAT_REF_BIT];
   wire clr_cnt = stat_wr & pwdata[STAT_CNT_LSB];
   wire cnt_full = &ign_cnt_q;
   // Time words inside the reference frame carry the cycle's epoch
   wire ref_hit = any_time & ref_frame;

   assign ign_cnt_d = clr_cnt ? CNT_W'(is_ign) :
                      (is_ign & ~cnt_full) ? ign_cnt_q + CNT_W'(1) : ign_cnt_q;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         date_seen_q <= 1'b0;
         time_seen_q <= 1'b0;
         zone_seen_q <= 1'b0;
         ref_ok_q <= 1'b0;
         ign_cnt_q <= '0;
      end else begin
         date_seen_q <= is_date | (date_seen_q & ~clr_date);
         time_seen_q <= is_time | (time_seen_q & ~clr_time);
         zone_seen_q <= is_zone | (zone_seen_q & ~clr_zone);
         ref_ok_q <= ref_hit | (ref_ok_q & ~clr_ref);
         ign_cnt_q <= ign_cnt_d;
      end
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   date_fields_a: assert property (is_date |=> date_valid_q &&
      month_q == $past(info_word_payload[13:10]) &&
      day_q == $past(info_word_payload[9:5]) &&
      year_q == $past(info_word_payload[4:0]))
      else $error("date fields not loaded");
   time_fields_a: assert property (is_time |=> time_valid_q &&
      coarse_sec_q == $past(info_word_payload[13:11]) &&
      minute_q == $past(info_word_payload[10:5]) &&
      hour_q == $past(info_word_payload[4:0]))
      else $error("time fields not loaded");
   format_gate_a: assert property (date_valid_q |->
      $past(info_word_format_code) == 3'h1 && !time_valid_q)
      else $error("date strobe without date format");
   zone_take_a: assert property (is_zone |=> zone_valid_q &&
      zone_code_q == $past(info_word_payload[8:4]) &&
      accurate_sec_q == $past(info_word_payload[13:11]))
      else $error("system message fields not taken");
   sys_ignore_a: assert property (is_ign && !is_time |=>
      !zone_valid_q && $stable(zone_code_q) && $stable(fine_sec_q))
      else $error("other subtype changed time");
   dst_flag_a: assert property (is_zone |=>
      standard_time_q == $past(info_word_payload[9]))
      else $error("standard time flag wrong");
   fine_sec_a: assert property (fine_sec_q ==
      6'((({coarse_sec_q, 3'h0} + accurate_sec_q) * 60) / 64))
      else $error("fine seconds mismatch");
   zone_pos_a: assert property (zone_code_q <= 5'h0C |->
      zone_offset_q == 11'(zone_code_q * 60))
      else $error("positive hour offset wrong");
   zone_neg_a: assert property (zone_code_q >= 5'h14 |->
      zone_offset_q == ((zone_code_q == 5'h14) ? -11'sd210 :
      11'sd60 * (signed'(11'(zone_code_q)) - 11'sd32)))
      else $error("negative offset wrong");
   apb_wait_a: assert property (apb_first |=> pready_q ##1 !pready_q)
      else $error("apb answer timing wrong");
   zone_rsvd_a: assert property (
      zone_reserved_q == (zone_code_q == ZONE_RSVD) &&
      (!zone_reserved_q || zone_offset_q == 11'sd0))
      else $error("reserved zone handling wrong");
   zone_half_a: assert property (
      (zone_code_q != 5'h0D || zone_offset_q == 11'sd210) &&
      (zone_code_q != 5'h0E || zone_offset_q == 11'sd270) &&
      (zone_code_q != 5'h0F || zone_offset_q == 11'sd330) &&
      (zone_code_q != 5'h11 || zone_offset_q == 11'sd345) &&
      (zone_code_q != 5'h12 || zone_offset_q == 11'sd390) &&
      (zone_code_q != 5'h13 || zone_offset_q == 11'sd570))
      else $error("fractional hour offset wrong");
   off_quiet_a: assert property (!en_q |=>
      !date_valid_q && !time_valid_q && !zone_valid_q)
      else $error("strobe while decoding disabled");
   strobe_src_a: assert property (
      (!time_valid_q || $past(is_time)) && (!zone_valid_q || $past(is_zone)))
      else $error("strobe without matching word");
   date_hold_a: assert property (!is_date |=>
      $stable(month_q) && $stable(day_q) && $stable(year_q))
      else $error("date changed without date word");
   time_hold_a: assert property (!is_time |=>
      $stable(minute_q) && $stable(hour_q) && $stable(coarse_sec_q))
      else $error("time changed without time word");
   zone_hold_a: assert property (!is_zone |=>
      $stable(zone_code_q) && $stable(standard_time_q) &&
      $stable(accurate_sec_q) && $stable(zone_offset_q))
      else $error("zone changed without system message");
   ign_count_a: assert property (
      is_ign && !cnt_full && !clr_cnt |=>
      ign_cnt_q == $past(ign_cnt_q) + 8'h01)
      else $error("ignored word not counted");
   apb_err_a: assert property (apb_first && !mapped |=>
      pslverr_q && prdata_q == 32'h0000_0000)
      else $error("unmapped access not refused");
   ref_mark_a: assert property (ref_hit |=> ref_ok_q)
      else $error("reference frame word not marked");

   date_seen_c: cover property (is_date ##1 date_valid_q);
   zone_seen_c: cover property (is_zone ##1 zone_valid_q);
   ign_seen_c: cover property (is_ign ##1 ign_cnt_q != '0);
   apb_read_c: cover property (apb_first && hit_stat && !pwrite);
   ref_mark_c: cover property (ref_hit ##1 ref_ok_q);
endmodule

// *** hdl/time_word_pkg.sv ***
// Constants and field layout for the time information word decoder
package time_word_pkg;
   localparam int FMT_W = 3;
   localparam int PAY_W = 14;
   localparam logic [2:0] FMT_DATE = 3'h1;
   localparam logic [2:0] FMT_TIME = 3'h2;
   localparam logic [2:0] FMT_SYS = 3'h5;
   localparam int MONTH_LSB = 10;
   localparam int MONTH_W = 4;
   localparam int DAY_LSB = 5;
   localparam int DAY_W = 5;
   localparam int YEAR_LSB = 0;
   localparam int YEAR_W = 5;
   localparam int CSEC_LSB = 11;
   localparam int SEC_W = 3;
   localparam int MIN_LSB = 5;
   localparam int MIN_W = 6;
   localparam int HOUR_LSB = 0;
   localparam int HOUR_W = 5;
   localparam int ASEC_LSB = 11;
   localparam int DST_BIT = 9;
   localparam int ZONE_LSB = 4;
   localparam int ZONE_W = 5;
   localparam int SUB_LSB = 0;
   localparam int SUB_W = 4;
   localparam logic [3:0] SUB_TIME_A = 4'h4;
   localparam logic [3:0] SUB_TIME_B = 4'h5;
   localparam int FINE_W = 6;
   localparam int OFS_W = 11;
   localparam logic [4:0] ZONE_RSVD = 5'h10;
   // APB map, byte addresses
   localparam int ADDR_W = 12;
   localparam logic [11:0] REG_DATE = 12'h000;
   localparam logic [11:0] REG_TIME = 12'h004;
   localparam logic [11:0] REG_ZONE = 12'h008;
   localparam logic [11:0] REG_CTRL = 12'h00C;
   localparam logic [11:0] REG_STAT = 12'h010;
   // Register field positions
   localparam int T_MIN_LSB = 8;
   localparam int T_HOUR_LSB = 16;
   localparam int T_CSEC_LSB = 24;
   localparam int T_ASEC_LSB = 28;
   localparam int Z_STD_BIT = 8;
   localparam int Z_RSVD_BIT = 9;
   localparam int Z_OFS_LSB = 16;
   localparam int CTRL_EN_BIT = 0;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam int STAT_DATE_BIT = 0;
   localparam int STAT_TIME_BIT = 1;
   localparam int STAT_ZONE_BIT = 2;
   localparam int STAT_REF_BIT = 3;
   localparam int STAT_CNT_LSB = 8;
   localparam int CNT_W = 8;
endpackage

// *** hdl/zone_offset_map.sv ***
// Time zone code to signed offset from GMT in minutes
`timescale 1ns/100ps
module zone_offset_map import time_word_pkg::*; (
   input wire logic [ZONE_W-1:0] zone_code,
   output logic signed [OFS_W-1:0] offset_min,
   output logic reserved
);
   localparam logic [4:0] HOURS_MAX = 5'h0C;
   localparam logic [5:0] CODE_SPAN = 6'h20;
   localparam logic signed [OFS_W-1:0] HOUR = 11'sh03C;
   logic signed [OFS_W-1:0] neg_hours;
   assign neg_hours = OFS_W'(signed'({1'b0, CODE_SPAN - {1'b0, zone_code}}));
   always_comb begin
      reserved = 1'b0;
      offset_min = '0;
      if (zone_code <= HOURS_MAX) begin
         offset_min = OFS_W'(signed'({6'h00, zone_code}) * HOUR);
      end else begin
         case (zone_code)
            5'h0D: offset_min = 11'sh0D2;
            5'h0E: offset_min = 11'sh10E;
            5'h0F: offset_min = 11'sh14A;
            ZONE_RSVD: reserved = 1'b1;
            5'h11: offset_min = 11'sh159;
            5'h12: offset_min = 11'sh186;
            5'h13: offset_min = 11'sh23A;
            5'h14: offset_min = -11'sh0D2;
            default: offset_min = OFS_W'(-(neg_hours * HOUR));
         endcase
      end
   end
endmodule
